/* design/cantg_guard.sv */
// Overview of operation
// RULE1 - dominant timeout returns driver to recessive
// RULE2 - high transmit clears timer, next low drives
// RULE3 - controller keeps bit rate at least 22kbps
// RULE4 - over-temperature forces recessive driver
// RULE5 - receive path works during over-temperature
// RULE6 - outputs high impedance until supply good
// RULE7 - receive and split enable after delay
// RULE8 - power-up starts in timeout state
// RULE9 - first dominant needs falling edge after delay
// RULE10 - undervoltage gives immediate shutdown
// RULE11 - receive output pulled high when undriven
// RULE12 - mode high is shutdown, mid is slowest
// RULE13 - slew control only below 1.1V
// RULE14 - controller matches slew setting to bit rate
// RULE15 - low transmit drives dominant, high recessive
// RULE16 - receive low on dominant, high recessive
// RULE17 - receive active within 40us of enable
// RULE18 - delays are counters with parameterised limits
// RULE19 - analog conditions arrive as digital flags
//
// top of the transceiver guard; flags are synchronous to CLK
// registers reached over a plain strobe port, read data one cycle later
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cantg_guard
	import cantg_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic TX_DATA,
	input wire logic BUS_DOMINANT,
	input wire logic SUPPLY_OK,
	input wire logic OVER_TEMP,
	input wire logic MODE_HIGH,
	input wire logic MODE_SLEW,
	input wire logic [1:0] SLEW_LEVEL,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic DRV_DOMINANT,
	output logic DRV_OE,
	output logic RX_OUT,
	output logic RX_OE,
	output logic SPLIT_OE,
	output logic [1:0] SLEW_SEL,
	output logic IRQ
);
	cantg_timer_if dom_if();
	cantg_timer_if en_if();
	cantg_timer dom_tmr (.clk(CLK), .nrst(NRST), .t(dom_if.tmr));
	cantg_timer en_tmr (.clk(CLK), .nrst(NRST), .t(en_if.tmr));

	// delay range bound for the receive enable check
	localparam int RX_LIMIT = RX_EN_CYC;
	cantg_state_t state;
	cantg_state_t next_state;
	logic tx_prev;
	logic rx_on;
	logic next_rx_on;
	logic [EV_W-1:0] status;
	logic [EV_W-1:0] next_status;
	logic [EV_W-1:0] mask;
	logic [EV_W-1:0] next_mask;
	logic [EV_W-1:0] events;
	logic [7:0] next_rdata;
	logic active;
	logic falling;
	logic next_drv;
	logic next_drv_oe;
	logic next_rx_out;
	logic [1:0] next_slew;

	// RULE19 flags in
	// RULE6 supply gate
	assign active = SUPPLY_OK && !MODE_HIGH;
	assign falling = tx_prev && !TX_DATA;

	function automatic logic [7:0] zext(input logic [EV_W-1:0] v);
		zext = {{(8-EV_W){1'b0}}, v};
	endfunction

	// RULE18 enable delay counter
	assign en_if.clear = !active;
	assign en_if.run = active;
	// done one cycle early: the outputs add a register stage
	assign en_if.limit = CNT_W'((RX_EN_CYC > TX_EN_CYC ?
		RX_EN_CYC : TX_EN_CYC) - 1);
	// RULE1 dominant timer
	assign dom_if.limit = CNT_W'(DOM_TIMEOUT_CYC - 1);
	// RULE2 clear on high
	assign dom_if.clear = TX_DATA || !active;
	assign dom_if.run = (state == CANTG_DOM);

	always_comb begin
		next_state = state;
		case (state)
			CANTG_OFF: begin
				// RULE8 start timed out
				if (active) begin
					next_state = CANTG_WAIT_EN;
				end
			end
			CANTG_WAIT_EN: begin
				// RULE9 wait enable delay
				if (en_if.done) begin
					next_state = CANTG_ARMED;
				end
			end
			CANTG_ARMED: begin
				// RULE9 falling edge only
				if (falling && !OVER_TEMP) begin
					next_state = CANTG_DOM;
				end
			end
			CANTG_DOM: begin
				// RULE1 timeout
				if (TX_DATA) begin
					next_state = CANTG_ARMED;
				end else if (dom_if.done) begin
					next_state = CANTG_TIMEOUT;
				end else if (OVER_TEMP) begin
					// no resume mid-run after cooling; needs a new edge
					next_state = CANTG_TIMEOUT;
				end
			end
			CANTG_TIMEOUT: begin
				// RULE2 wait for high
				if (TX_DATA) begin
					next_state = CANTG_ARMED;
				end
			end
			default: begin
				next_state = CANTG_OFF;
			end
		endcase
		// RULE10 immediate shutdown
		if (!active) begin
			next_state = CANTG_OFF;
		end
	end

	always_comb begin
		// RULE7 receive enable delay
		// RULE17 within 40us
		next_rx_on = active && (rx_on || en_if.done);
		// RULE15 dominant on low
		// RULE4 thermal forces recessive
		next_drv = (next_state == CANTG_DOM) && !OVER_TEMP && active;
		next_drv_oe = next_drv;
		// RULE16 receive follows bus
		// RULE5 receiver still runs
		// RULE11 high when undriven
		next_rx_out = !(next_rx_on && BUS_DOMINANT);
		// RULE12 mid level slowest
		// RULE13 slew only below 1.1V
		next_slew = MODE_SLEW ? SLEW_LEVEL : SLEW_MIN;
		// RULE3 bit rate is the controller's duty
		// RULE14 slew choice is the controller's duty
	end

	always_comb begin
		events = '0;
		events[EV_TIMEOUT] = (state == CANTG_DOM) && dom_if.done && !TX_DATA;
		events[EV_OVERTEMP] = OVER_TEMP;
		events[EV_UNDERVOLT] = !SUPPLY_OK;
		next_mask = mask;
		next_status = status;
		if (WR && ADDR == ADDR_MASK) begin
			next_mask = WDATA[EV_W-1:0];
		end
		if (WR && ADDR == ADDR_STATUS) begin
			next_status = status & ~WDATA[EV_W-1:0];
		end
		// set wins over the write-one clear
		next_status = next_status | events;
		next_rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				ADDR_STATUS: next_rdata = zext(status);
				ADDR_MASK: next_rdata = zext(mask);
				ADDR_STATE: next_rdata = {5'h00, state};
				ADDR_SLEW: next_rdata = {6'h00, SLEW_SEL};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state <= CANTG_OFF;
			tx_prev <= 1'b1;
			rx_on <= 1'b0;
			status <= '0;
			mask <= '0;
			RDATA <= 8'h00;
			DRV_DOMINANT <= 1'b0;
			DRV_OE <= 1'b0;
			RX_OUT <= 1'b1;
			RX_OE <= 1'b0;
			SPLIT_OE <= 1'b0;
			SLEW_SEL <= SLEW_MIN;
			IRQ <= 1'b0;
		end else begin
			state <= next_state;
			tx_prev <= TX_DATA;
			rx_on <= next_rx_on;
			status <= next_status;
			mask <= next_mask;
			RDATA <= next_rdata;
			DRV_DOMINANT <= next_drv;
			DRV_OE <= next_drv_oe;
			RX_OUT <= next_rx_out;
			RX_OE <= next_rx_on;
			SPLIT_OE <= next_rx_on;
			SLEW_SEL <= next_slew;
			IRQ <= |(next_status & next_mask);
		end
	end

	// RULE4 thermal check
	property p_overtemp;
		@(posedge CLK) disable iff (!NRST) OVER_TEMP |=> !DRV_DOMINANT;
	endproperty
	a_overtemp: assert property (p_overtemp) else $error("drive in overtemp"); // RULE4
	property p_undervolt;
		@(posedge CLK) disable iff (!NRST)
			!SUPPLY_OK |=> !DRV_OE && !RX_OE && !SPLIT_OE && RX_OUT;
	endproperty
	a_undervolt: assert property (p_undervolt) else $error("not shut down"); // RULE10
	property p_txhigh;
		@(posedge CLK) disable iff (!NRST) TX_DATA |=> !DRV_DOMINANT;
	endproperty
	a_txhigh: assert property (p_txhigh) else $error("dominant on high"); // RULE15
	property p_edge;
		@(posedge CLK) disable iff (!NRST)
			$rose(DRV_DOMINANT) |-> $past(tx_prev) && !$past(TX_DATA);
	endproperty
	a_edge: assert property (p_edge) else $error("dominant without edge"); // RULE9
	property p_timeout;
		@(posedge CLK) disable iff (!NRST)
			(state == CANTG_DOM && dom_if.done && !TX_DATA) |=> !DRV_DOMINANT;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout ignored"); // RULE1
	property p_rxhigh;
		@(posedge CLK) disable iff (!NRST) !RX_OE |-> RX_OUT;
	endproperty
	a_rxhigh: assert property (p_rxhigh) else $error("rx low undriven"); // RULE11
	property p_rxlate;
		@(posedge CLK) disable iff (!NRST)
			$rose(active) ##1 active [*8] |-> !RX_OE;
	endproperty
	a_rxlate: assert property (p_rxlate) else $error("rx enabled early"); // RULE7
	property p_split;
		@(posedge CLK) disable iff (!NRST) RX_OE == SPLIT_OE;
	endproperty
	a_split: assert property (p_split) else $error("split mismatch"); // RULE7
	property p_shut;
		@(posedge CLK) disable iff (!NRST) MODE_HIGH |=> !DRV_OE && !RX_OE;
	endproperty
	a_shut: assert property (p_shut) else $error("mode high active"); // RULE12
	property p_rxdom;
		@(posedge CLK) disable iff (!NRST)
			RX_OE && active && BUS_DOMINANT |=> !RX_OUT;
	endproperty
	a_rxdom: assert property (p_rxdom) else $error("rx high"); // RULE16
	property p_rxrec;
		@(posedge CLK) disable iff (!NRST)
			!BUS_DOMINANT |=> RX_OUT;
	endproperty
	a_rxrec: assert property (p_rxrec) else $error("rx low"); // RULE16
	property p_hotrx;
		@(posedge CLK) disable iff (!NRST)
			OVER_TEMP && RX_OE && active |=> RX_OE;
	endproperty
	a_hotrx: assert property (p_hotrx) else $error("rx off when hot"); // RULE5
	property p_startrec;
		@(posedge CLK) disable iff (!NRST)
			(state == CANTG_OFF || state == CANTG_WAIT_EN) |=> !DRV_DOMINANT;
	endproperty
	a_startrec: assert property (p_startrec) else $error("early drive"); // RULE8
	property p_noedge;
		@(posedge CLK) disable iff (!NRST)
			state == CANTG_ARMED && !falling |=> !DRV_DOMINANT;
	endproperty
	a_noedge: assert property (p_noedge) else $error("drive no edge"); // RULE9
	property p_edgedrv;
		@(posedge CLK) disable iff (!NRST)
			state == CANTG_ARMED && falling && !OVER_TEMP && active
			|=> DRV_DOMINANT;
	endproperty
	a_edgedrv: assert property (p_edgedrv) else $error("edge lost"); // RULE2
	property p_clear;
		@(posedge CLK) disable iff (!NRST)
			TX_DATA |=> !dom_if.done;
	endproperty
	a_clear: assert property (p_clear) else $error("timer kept"); // RULE2
	property p_tohold;
		@(posedge CLK) disable iff (!NRST)
			state == CANTG_TIMEOUT && !TX_DATA |=> !DRV_DOMINANT;
	endproperty
	a_tohold: assert property (p_tohold) else $error("drive after timeout"); // RULE1
	property p_oepair;
		@(posedge CLK) disable iff (!NRST)
			DRV_OE == DRV_DOMINANT;
	endproperty
	a_oepair: assert property (p_oepair) else $error("enable split"); // RULE15
	property p_domhold;
		@(posedge CLK) disable iff (!NRST)
			state == CANTG_DOM && !TX_DATA && !OVER_TEMP && active
			&& !dom_if.done |=> DRV_DOMINANT;
	endproperty
	a_domhold: assert property (p_domhold) else $error("dominant dropped"); // RULE15
	property p_rxtime;
		@(posedge CLK) disable iff (!NRST)
			$rose(active) |-> ##[1:RX_LIMIT] (RX_OE || !active);
	endproperty
	a_rxtime: assert property (p_rxtime) else $error("rx enable late"); // RULE17
	property p_rxkeep;
		@(posedge CLK) disable iff (!NRST)
			RX_OE && active |=> RX_OE;
	endproperty
	a_rxkeep: assert property (p_rxkeep) else $error("rx enable lost"); // RULE7
	property p_slew;
		@(posedge CLK) disable iff (!NRST)
			MODE_SLEW |=> SLEW_SEL == $past(SLEW_LEVEL);
	endproperty
	a_slew: assert property (p_slew) else $error("slew not taken"); // RULE13
	property p_slewmin;
		@(posedge CLK) disable iff (!NRST)
			!MODE_SLEW |=> SLEW_SEL == SLEW_MIN;
	endproperty
	a_slewmin: assert property (p_slewmin) else $error("slew not min"); // RULE12
	property p_hotflag;
		@(posedge CLK) disable iff (!NRST)
			OVER_TEMP |=> status[EV_OVERTEMP];
	endproperty
	a_hotflag: assert property (p_hotflag) else $error("hot not flagged"); // RULE4
	property p_offout;
		@(posedge CLK) disable iff (!NRST)
			!active |=> !DRV_OE && !RX_OE && !SPLIT_OE;
	endproperty
	a_offout: assert property (p_offout) else $error("driven while off"); // RULE6
	property p_lowsup;
		@(posedge CLK) disable iff (!NRST)
			!SUPPLY_OK |=> state == CANTG_OFF;
	endproperty
	a_lowsup: assert property (p_lowsup) else $error("no brownout stop"); // RULE10
endmodule
`default_nettype wire

/* design/cantg_pkg.sv */
// shared constants for the transceiver guard logic
// assumes a 10 MHz core clock; analog conditions arrive as digital flags
package cantg_pkg;
	localparam int CLK_NS = 100;
	localparam int DOM_TIMEOUT_US = 2000;
	localparam int RX_EN_DELAY_US = 40;
	localparam int TX_EN_DELAY_US = 40;
	localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * 1000 / CLK_NS;
	localparam int RX_EN_CYC = RX_EN_DELAY_US * 1000 / CLK_NS;
	localparam int TX_EN_CYC = TX_EN_DELAY_US * 1000 / CLK_NS;
	localparam int CNT_W = 16;
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_MASK = 4'h1;
	localparam logic [3:0] ADDR_STATE = 4'h2;
	localparam logic [3:0] ADDR_SLEW = 4'h3;
	localparam int EV_TIMEOUT = 0;
	localparam int EV_OVERTEMP = 1;
	localparam int EV_UNDERVOLT = 2;
	localparam int EV_W = 3;
	localparam logic [1:0] SLEW_MIN = 2'h0;
	typedef enum logic [2:0] {CANTG_OFF, CANTG_WAIT_EN, CANTG_ARMED,
		CANTG_DOM, CANTG_TIMEOUT} cantg_state_t;
endpackage

/* design/cantg_timer_if.sv */
// timer request and done flags between guard and its counter
// one clock domain, no tristate
`timescale 1ns/1ps
`default_nettype none
interface cantg_timer_if;
	logic clear;
	logic run;
	logic [15:0] limit;
	logic done;
	modport ctl(output clear, output run, output limit, input done);
	modport tmr(input clear, input run, input limit, output done);
endinterface
`default_nettype wire

/* design/cantg_timer.sv */
// generic up counter that flags when its limit is reached
// assumes clear has priority over run
`timescale 1ns/1ps
`default_nettype none
module cantg_timer
	import cantg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	cantg_timer_if.tmr t
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	always_comb begin
		next_count = count;
		if (t.clear) begin
			next_count = '0;
		end else if (t.run && count != t.limit) begin
			next_count = count + 16'h0001;
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
	assign t.done = (count == t.limit);
endmodule
`default_nettype wire

/* dv/cantg_ctl_model.sv */
// controller model: transmit data and slew request
// assumes the bench changes its inputs just after rising edges
`timescale 1ns/1ps
`default_nettype none
module cantg_ctl_model
	import cantg_pkg::*;
#(
	parameter int MAX_DOM = 5000
)(
	input wire logic clk,
	input wire logic dom_req,
	input wire logic stuck,
	input wire logic fast,
	output var logic tx_data,
	output logic [1:0] slew_level
);
	int run = 0;
	initial tx_data = 1'b1;
	// dominant run cap
	// 11 bits at 22kbps fit 0.5ms; stuck models a faulty controller
	always @(posedge clk) begin
		if (dom_req && (stuck || run < MAX_DOM)) begin
			tx_data <= 1'b0;
			run <= run + 1;
		end else begin
			tx_data <= 1'b1;
			run <= 0;
		end
	end
	assign slew_level = fast ? 2'h3 : SLEW_MIN;
endmodule
`default_nettype wire

/* dv/test_cantg_guard.sv */
// self-checking bench for the transceiver guard
// assumes a 10 MHz clock and fixed delay constants from the package
`timescale 1ns/1ps
`default_nettype none
module test_cantg_guard;
	import cantg_pkg::*;
	logic CLK = 0, NRST = 0, BUS_DOMINANT = 0, SUPPLY_OK = 0, OVER_TEMP = 0;
	logic MODE_HIGH = 0, MODE_SLEW = 0, WR = 0, RD = 0, TX_DATA;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00, RDATA;
	logic [1:0] SLEW_LEVEL, SLEW_SEL;
	logic DRV_DOMINANT, DRV_OE, RX_OUT, RX_OE, SPLIT_OE, IRQ;
	logic dom_req = 0, stuck = 0, fast = 0;
	int errors = 0, n_tests = 0, cycles = 0, n;
	logic [7:0] d;
	always #50 CLK = ~CLK;
	cantg_guard cantg_guard_i(.CLK(CLK), .NRST(NRST), .TX_DATA(TX_DATA),
		.BUS_DOMINANT(BUS_DOMINANT), .SUPPLY_OK(SUPPLY_OK),
		.OVER_TEMP(OVER_TEMP), .MODE_HIGH(MODE_HIGH), .MODE_SLEW(MODE_SLEW),
		.SLEW_LEVEL(SLEW_LEVEL), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .DRV_DOMINANT(DRV_DOMINANT), .DRV_OE(DRV_OE),
		.RX_OUT(RX_OUT), .RX_OE(RX_OE), .SPLIT_OE(SPLIT_OE),
		.SLEW_SEL(SLEW_SEL), .IRQ(IRQ));
	cantg_ctl_model cantg_ctl_model_i(.clk(CLK), .dom_req(dom_req),
		.stuck(stuck), .fast(fast), .tx_data(TX_DATA),
		.slew_level(SLEW_LEVEL));
	task automatic print_verdict;
		if (errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge CLK) begin ADDR <= a; RD <= 1'b1; end
		@(posedge CLK) RD <= 1'b0;
		#1 d = RDATA;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge CLK) begin ADDR <= a; WDATA <= v; WR <= 1'b1; end
		@(posedge CLK) WR <= 1'b0;
		#1;
	endtask
	// bounded wait, n counts cycles taken
	task automatic wait_oe(input logic v, input int lim);
		n = 0;
		while (RX_OE !== v && n < lim) begin cyc(1); n++; end
	endtask
	task automatic wait_drv(input logic v, input int lim);
		n = 0;
		while (DRV_DOMINANT !== v && n < lim) begin cyc(1); n++; end
	endtask
	task automatic off_chk;
		chk("oe,rx", 4'h1, {DRV_OE, RX_OE, SPLIT_OE, RX_OUT});
	endtask
	task automatic t_powerup;
		@(posedge CLK) dom_req <= 1'b1;
		cyc(3);
		off_chk();
		@(posedge CLK) SUPPLY_OK <= 1'b1;
		wait_oe(1'b1, 500);
		chk("rx delay", 1, n >= RX_EN_CYC - 3 && n <= RX_EN_CYC + 3);
		chk("split", 1, SPLIT_OE);
		chk("drv", 0, DRV_DOMINANT);
		@(posedge CLK) BUS_DOMINANT <= 1'b1;
		cyc(3);
		chk("rx dom", 0, RX_OUT);
		@(posedge CLK) BUS_DOMINANT <= 1'b0;
		cyc(3);
		chk("rx rec", 1, RX_OUT);
		chk("drv held", 0, DRV_DOMINANT);
	endtask
	task automatic redrive;
		@(posedge CLK) dom_req <= 1'b0;
		cyc(3);
		@(posedge CLK) dom_req <= 1'b1;
		cyc(4);
		chk("dom", 3, {DRV_DOMINANT, DRV_OE});
	endtask
	task automatic t_timeout;
		@(posedge CLK) stuck <= 1'b1;
		wait_drv(1'b0, 21000);
		chk("timeout", 1, n > DOM_TIMEOUT_CYC - 12 && n <= DOM_TIMEOUT_CYC);
		rd(ADDR_STATUS);
		chk("status", 1, d[EV_TIMEOUT]);
		rd(ADDR_STATE);
		chk("state", CANTG_TIMEOUT, d);
		chk("irq masked", 0, IRQ);
		wr(ADDR_MASK, 8'h01);
		cyc(2);
		chk("irq", 1, IRQ);
		rd(ADDR_MASK);
		chk("mask", 1, d);
		@(posedge CLK) begin stuck <= 1'b0; dom_req <= 1'b0; end
		cyc(3);
		wr(ADDR_STATUS, 8'h01);
		cyc(2);
		chk("irq clr", 0, IRQ);
		rd(4'h9);
		chk("unmapped", 0, d);
		redrive();
	endtask
	task automatic t_overtemp;
		@(posedge CLK) begin OVER_TEMP <= 1'b1; BUS_DOMINANT <= 1'b1; end
		cyc(3);
		chk("hot drv", 0, DRV_DOMINANT);
		chk("hot rx", 2, {RX_OE, RX_OUT});
		rd(ADDR_STATUS);
		chk("hot flag", 1, d[EV_OVERTEMP]);
		@(posedge CLK) begin OVER_TEMP <= 1'b0; BUS_DOMINANT <= 1'b0; end
		cyc(3);
		chk("cool drv", 0, DRV_DOMINANT);
	endtask
	task automatic t_modes;
		@(posedge CLK) begin MODE_SLEW <= 1'b1; fast <= 1'b1; end
		cyc(3);
		chk("slew", 3, SLEW_SEL);
		rd(ADDR_SLEW);
		chk("slew rd", 3, d);
		@(posedge CLK) MODE_SLEW <= 1'b0;
		cyc(3);
		chk("slew min", SLEW_MIN, SLEW_SEL);
		redrive();
		@(posedge CLK) MODE_HIGH <= 1'b1;
		cyc(2);
		off_chk();
		@(posedge CLK) MODE_HIGH <= 1'b0;
		wait_oe(1'b1, 500);
		chk("re-enable", 1, RX_OE);
		@(posedge CLK) SUPPLY_OK <= 1'b0;
		cyc(2);
		off_chk();
	endtask
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (5) @(posedge CLK);
		NRST <= 1'b1;
		t_powerup();
		redrive();
		t_timeout();
		t_overtemp();
		t_modes();
		print_verdict();
	end
endmodule
`default_nettype wire
